/* rtl/ccs_pkg.sv */
// Package: constants and types shared by the clock source switch.
`default_nettype none
package ccs_pkg;
	// Register byte offsets, one aligned 32-bit word each.
	localparam logic [3:0] CCS_OFF_OSC_CTRL = 4'h0;
	localparam logic [3:0] CCS_OFF_OSC_TUNE = 4'h4;
	localparam logic [3:0] CCS_OFF_SEC_CTRL = 4'h8;
	localparam logic [3:0] CCS_OFF_HALT     = 4'hC;

	// Field positions in the oscillator control register.
	localparam int CCS_POS_SRC_LO  = 0;
	localparam int CCS_POS_INT_OK  = 2;
	localparam int CCS_POS_PRI_OK  = 3;
	localparam int CCS_POS_IFS_LO  = 4;
	localparam int CCS_POS_IDLE    = 7;
	// Low-frequency source select bit in the tuning register.
	localparam int CCS_POS_LFSS    = 7;
	// Enable and running bits in the secondary control register.
	localparam int CCS_POS_SEC_EN  = 3;
	localparam int CCS_POS_SEC_RUN = 6;
	// Halt register: bit 0 executes power-down; reads show the mode.
	localparam int CCS_POS_HALT    = 0;
	localparam int CCS_POS_IDLING  = 1;

	// Values after reset.
	localparam logic [1:0] CCS_RST_SRC  = 2'h0;
	localparam logic [2:0] CCS_RST_IFS  = 3'h4;
	localparam logic       CCS_RST_IDLE = 1'b0;
	localparam logic       CCS_RST_LFSS = 1'b0;
	localparam logic       CCS_RST_SEN  = 1'b0;

	// Frequency select codes with special meaning.
	localparam logic [2:0] CCS_IFS_LOW  = 3'h0;
	localparam logic [2:0] CCS_IFS_FULL = 3'h7;

	// Switch-over pause in source cycles.
	localparam logic [1:0] CCS_OLD_CYCLES = 2'h2;
	localparam logic [1:0] CCS_NEW_CYCLES = 2'h3;

	// Clock sources as decoded from the select field.
	typedef enum logic [1:0] {
		CCS_SRC_PRI,
		CCS_SRC_SEC,
		CCS_SRC_INT
	} ccs_src_e;

	// Switch and power state.
	typedef enum logic [2:0] {
		CCS_ST_RUN,
		CCS_ST_DRAIN_OLD,
		CCS_ST_WAIT_NEW,
		CCS_ST_SLEEP,
		CCS_ST_IDLE
	} ccs_state_e;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} ccs_avm_req_s;
endpackage : ccs_pkg
`default_nettype wire

/* rtl/ccs_osc_sync.sv */
// Module: three-stage synchroniser and rising-edge detector for one input.
`default_nettype none
module ccs_osc_sync
	import ccs_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic osc_in,
	output logic      rise_pulse
);
	logic s1_r;      // First stage, read only by the second.
	logic s2_r;      // Second stage.
	logic s3_r;      // Third stage.
	logic level_r;   // Accepted level once two stages agree.

	// Shift the pin through three flops.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= osc_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only when second and third stages agree.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	// One pulse per accepted rising edge.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_pulse <= 1'b0;
		end else begin
			rise_pulse <= (s2_r == s3_r) && s3_r && !level_r;
		end
	end
endmodule : ccs_osc_sync
`default_nettype wire

/* rtl/ccs_clock_switch.sv */
// Module: system clock source selection, switch-over and power-down control.
// Function
// [RQ1] Two-bit select picks primary, secondary or internal.
// [RQ2] New select takes effect after brief transition.
// [RQ3] Any reset restores select field default.
// [RQ4] Three-bit field picks internal block frequency.
// [RQ5] Frequency change acts at once when internal.
// [RQ6] Reset sets internal block to 1 MHz.
// [RQ7] Code 000 with bit set: postscaled 31.25 kHz.
// [RQ8] Code 000 with bit clear: RC, oscillator off.
// [RQ9] Watchdog and monitor always use RC source.
// [RQ10] Primary flag after start-up timers, primary driving.
// [RQ11] Internal flag when block stable and driving.
// [RQ12] Secondary flag while secondary drives clock.
// [RQ13] At most one running flag set.
// [RQ14] Power-down enters sleep or idle per bit.
// [RQ15] Secondary select ignored while oscillator disabled.
// [RQ16] Software starts secondary oscillator before selecting.
// [RQ17] Switching produces no glitch on system clock.
// [RQ18] Pause: two old plus three-four new cycles.
// [RQ19] Running flags change only after pause ends.
`default_nettype none
module ccs_clock_switch
	import ccs_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire ccs_avm_req_s  avm_req,
	output logic [31:0]        avm_readdata,
	output logic               avm_waitrequest,
	input  wire logic          pri_osc_in,
	input  wire logic          sec_osc_in,
	input  wire logic          main_osc_in,
	input  wire logic          lprc_osc_in,
	input  wire logic          pri_startup_done,
	input  wire logic          int_osc_stable,
	input  wire logic          wake_req,
	output logic               sys_clk_en,
	output logic               periph_clk_en,
	output logic               main_osc_enable,
	output logic               wdt_clk_tick,
	output logic               sleep_active,
	output logic               idle_active
);
	// Software-visible control fields.
	logic [1:0] clock_source_select_r;    // Requested source.
	logic [2:0] internal_freq_select_r;   // Internal block frequency.
	logic       idle_on_halt_select_r;    // Idle instead of sleep.
	logic       low_freq_source_select_r; // Postscaled low frequency.
	logic       secondary_osc_enable_r;   // Secondary oscillator on.

	// Status flags, updated only when a source really drives the clock.
	logic       primary_running_flag_r;
	logic       internal_stable_flag_r;
	logic       secondary_running_flag_r;

	// Switch machinery.
	ccs_state_e state_r;        // Present switch or power state.
	ccs_src_e   cur_src_r;      // Source that drives the clock now.
	ccs_src_e   new_src_r;      // Source being switched to.
	logic [1:0] cyc_cnt_r;      // Source cycles counted in the pause.
	logic [7:0] post_cnt_r;     // Postscaler of the main oscillator.

	// Synchronised rising edges of the four oscillators.
	logic pri_rise;
	logic sec_rise;
	logic main_rise;
	logic lprc_rise;

	// Bus decode helpers.
	logic       bus_req;        // Read or write pending.
	logic       bus_wr;         // Write takes effect this edge.
	logic [31:0] rd_word;       // Read data selected by address.
	ccs_src_e   sel_src;        // Decoded requested source.
	logic       int_tick;       // Internal block output tick.
	logic       cur_tick;       // Tick of the driving source.
	logic       new_tick;       // Tick of the target source.
	logic       halt_wr;        // Power-down executed.

	// One synchroniser per oscillator pin.
	ccs_osc_sync u_sync_pri (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.osc_in     (pri_osc_in),
		.rise_pulse (pri_rise)
	);
	ccs_osc_sync u_sync_sec (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.osc_in     (sec_osc_in),
		.rise_pulse (sec_rise)
	);
	ccs_osc_sync u_sync_main (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.osc_in     (main_osc_in),
		.rise_pulse (main_rise)
	);
	ccs_osc_sync u_sync_lprc (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.osc_in     (lprc_osc_in),
		.rise_pulse (lprc_rise)
	);

	// A write lands on the edge where waitrequest is seen low.
	assign bus_req = avm_req.read || avm_req.write;
	assign bus_wr  = avm_req.write && !avm_waitrequest &&
	                 avm_req.byteenable[0];
	assign halt_wr = bus_wr && (avm_req.address == CCS_OFF_HALT) &&
	                 avm_req.writedata[CCS_POS_HALT] &&
	                 (state_r == CCS_ST_RUN);

	// Decode the select field; both upper codes mean internal.
	always_comb begin
		if (clock_source_select_r[1]) begin
			sel_src = CCS_SRC_INT;  // [RQ1]
		end else if (clock_source_select_r[0]) begin
			sel_src = CCS_SRC_SEC;  // [RQ1]
		end else begin
			sel_src = CCS_SRC_PRI;  // [RQ1]
		end
	end

	// Postscaler counts main oscillator edges; it freezes while off.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			post_cnt_r <= 8'h00;
		end else if (main_osc_enable && main_rise) begin
			post_cnt_r <= post_cnt_r + 8'h01;
		end
	end

	// Internal block output: divide by 2^(7-code), or 256 for code 000 with the low-frequency bit set.
	// The frequency field is used directly so a change acts at once.
	always_comb begin
		if (internal_freq_select_r == CCS_IFS_LOW) begin
			if (low_freq_source_select_r) begin
				int_tick = main_rise && (&post_cnt_r);  // [RQ7]
			end else begin
				int_tick = lprc_rise;                   // [RQ8]
			end
		end else begin
			int_tick = main_rise &&
			  (&(post_cnt_r[6:0] |
			     ~(7'h7F >> internal_freq_select_r))); // [RQ4] [RQ5]
		end
	end

	// Pick the tick of the driving and of the target source.
	always_comb begin
		case (cur_src_r)
			CCS_SRC_PRI: cur_tick = pri_rise;
			CCS_SRC_SEC: cur_tick = sec_rise;
			default:     cur_tick = int_tick;
		endcase
		case (new_src_r)
			CCS_SRC_PRI: new_tick = pri_rise;
			CCS_SRC_SEC: new_tick = sec_rise;
			default:     new_tick = int_tick;
		endcase
	end

	// Control fields written by software.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_source_select_r    <= CCS_RST_SRC;   // [RQ3]
			internal_freq_select_r   <= CCS_RST_IFS;   // [RQ6]
			idle_on_halt_select_r    <= CCS_RST_IDLE;
			low_freq_source_select_r <= CCS_RST_LFSS;
			secondary_osc_enable_r   <= CCS_RST_SEN;
		end else if (bus_wr) begin
			if (avm_req.address == CCS_OFF_OSC_CTRL) begin
				// Secondary code is dropped while its oscillator is off.
				if (avm_req.writedata[CCS_POS_SRC_LO +: 2] != 2'h1 ||
				    secondary_osc_enable_r) begin
					clock_source_select_r <=
					  avm_req.writedata[CCS_POS_SRC_LO +: 2]; // [RQ15]
				end
				internal_freq_select_r <=
				  avm_req.writedata[CCS_POS_IFS_LO +: 3];     // [RQ4]
				idle_on_halt_select_r <=
				  avm_req.writedata[CCS_POS_IDLE];
			end else if (avm_req.address == CCS_OFF_OSC_TUNE) begin
				low_freq_source_select_r <=
				  avm_req.writedata[CCS_POS_LFSS];
			end else if (avm_req.address == CCS_OFF_SEC_CTRL) begin
				secondary_osc_enable_r <=
				  avm_req.writedata[CCS_POS_SEC_EN];
			end
		end
	end

	// Switch and power state machine. The system clock is never cut in
	// mid-cycle: enables stop between ticks of the old source and resume
	// only on ticks of the new one, so no short pulse can appear.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= CCS_ST_RUN;
			cur_src_r <= CCS_SRC_PRI;
			new_src_r <= CCS_SRC_PRI;
			cyc_cnt_r <= 2'h0;
		end else begin
			case (state_r)
				CCS_ST_RUN: begin
					if (halt_wr) begin
						// Idle keeps peripherals clocked; sleep stops all.
						state_r <= idle_on_halt_select_r ?
						           CCS_ST_IDLE : CCS_ST_SLEEP;  // [RQ14]
					end else if (sel_src != cur_src_r) begin
						new_src_r <= sel_src;                 // [RQ2]
						cyc_cnt_r <= 2'h0;
						state_r   <= CCS_ST_DRAIN_OLD;        // [RQ17]
					end
				end
				CCS_ST_DRAIN_OLD: begin
					// Two cycles of the old source pass first.
					if (cur_tick) begin
						if (cyc_cnt_r == CCS_OLD_CYCLES - 2'h1) begin
							cyc_cnt_r <= 2'h0;
							state_r   <= CCS_ST_WAIT_NEW;     // [RQ18]
						end else begin
							cyc_cnt_r <= cyc_cnt_r + 2'h1;
						end
					end
				end
				CCS_ST_WAIT_NEW: begin
					// Three new cycles; the next one drives the clock,
					// so the pause spans three to four new cycles.
					if (new_tick) begin
						if (cyc_cnt_r == CCS_NEW_CYCLES - 2'h1) begin
							cur_src_r <= new_src_r;           // [RQ18]
							state_r   <= CCS_ST_RUN;
						end else begin
							cyc_cnt_r <= cyc_cnt_r + 2'h1;
						end
					end
				end
				CCS_ST_SLEEP, CCS_ST_IDLE: begin
					if (wake_req) begin
						state_r <= CCS_ST_RUN;
					end
				end
				default: begin
					state_r <= CCS_ST_RUN;
				end
			endcase
		end
	end

	// Clock enables: core only while running, peripherals in idle too.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_clk_en    <= 1'b0;
			periph_clk_en <= 1'b0;
		end else begin
			sys_clk_en    <= (state_r == CCS_ST_RUN) && cur_tick; // [RQ17]
			periph_clk_en <= ((state_r == CCS_ST_RUN) ||
			                  (state_r == CCS_ST_IDLE)) && cur_tick;
		end
	end

	// Power mode outputs follow the state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_active <= 1'b0;
			idle_active  <= 1'b0;
		end else begin
			sleep_active <= (state_r == CCS_ST_SLEEP); // [RQ14]
			idle_active  <= (state_r == CCS_ST_IDLE);  // [RQ14]
		end
	end

	// The main oscillator is shut down in the RC low-frequency setting;
	// watchdog ticks come from the RC source regardless of that setting.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_osc_enable <= 1'b1;
			wdt_clk_tick    <= 1'b0;
		end else begin
			main_osc_enable <= !((internal_freq_select_r == CCS_IFS_LOW) &&
			                     !low_freq_source_select_r);  // [RQ8]
			wdt_clk_tick    <= lprc_rise;                    // [RQ9]
		end
	end

	// Running flags derive from the source in use, never the target, so
	// they cannot change before the pause ends and at most one is set.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_running_flag_r   <= 1'b0;
			internal_stable_flag_r   <= 1'b0;
			secondary_running_flag_r <= 1'b0;
		end else begin
			primary_running_flag_r   <= (cur_src_r == CCS_SRC_PRI) &&
			                            pri_startup_done;  // [RQ10] [RQ19]
			// The RC low-frequency setting leaves the internal flag clear.
			internal_stable_flag_r   <= (cur_src_r == CCS_SRC_INT) &&
			  int_osc_stable &&
			  !((internal_freq_select_r == CCS_IFS_LOW) &&
			    !low_freq_source_select_r);              // [RQ11] [RQ13]
			secondary_running_flag_r <= (cur_src_r == CCS_SRC_SEC);
			                                             // [RQ12] [RQ19]
		end
	end

	// Read multiplexer; unmapped addresses read zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		if (avm_req.address == CCS_OFF_OSC_CTRL) begin
			rd_word[CCS_POS_SRC_LO +: 2] = clock_source_select_r;
			rd_word[CCS_POS_INT_OK]      = internal_stable_flag_r;
			rd_word[CCS_POS_PRI_OK]      = primary_running_flag_r;
			rd_word[CCS_POS_IFS_LO +: 3] = internal_freq_select_r;
			rd_word[CCS_POS_IDLE]        = idle_on_halt_select_r;
		end else if (avm_req.address == CCS_OFF_OSC_TUNE) begin
			rd_word[CCS_POS_LFSS] = low_freq_source_select_r;
		end else if (avm_req.address == CCS_OFF_SEC_CTRL) begin
			rd_word[CCS_POS_SEC_EN]  = secondary_osc_enable_r;
			rd_word[CCS_POS_SEC_RUN] = secondary_running_flag_r;
		end else if (avm_req.address == CCS_OFF_HALT) begin
			rd_word[CCS_POS_HALT]   = sleep_active;
			rd_word[CCS_POS_IDLING] = idle_active;
		end
	end

	// Waitrequest rests high and drops for one cycle per request, so
	// every access takes exactly one wait state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avm_waitrequest <= 1'b1;
		end else begin
			avm_waitrequest <= !(bus_req && avm_waitrequest);
		end
	end

	// Read data are captured together with the waitrequest drop.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avm_readdata <= 32'h0000_0000;
		end else if (avm_req.read && avm_waitrequest) begin
			avm_readdata <= rd_word;
		end
	end
endmodule : ccs_clock_switch
`default_nettype wire

/* verif/ccs_clock_switch_props.sv */
// Checker: port-level properties of the clock source switch.
`default_nettype none
module ccs_clock_switch_props
	import ccs_pkg::*;
(
	input wire logic         core_clk,
	input wire logic         rst_n,
	input wire ccs_avm_req_s avm_req,
	input wire logic [31:0]  avm_readdata,
	input wire logic         avm_waitrequest,
	input wire logic         lprc_osc_in,
	input wire logic         wake_req,
	input wire logic         sys_clk_en,
	input wire logic         periph_clk_en,
	input wire logic         main_osc_enable,
	input wire logic         wdt_clk_tick,
	input wire logic         sleep_active,
	input wire logic         idle_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// A taken read request is answered for exactly one cycle.
	bus_answer_a: assert property (
		avm_req.read && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
		else $error("bus answer not one cycle");
	// An enable is a single pulse; a double pulse would be a glitch.
	sys_pulse_a: assert property (sys_clk_en |=> !sys_clk_en)
		else $error("system enable glitch");
	periph_pulse_a: assert property (periph_clk_en |=> !periph_clk_en)
		else $error("peripheral enable glitch");
	// The watchdog tick follows every rise of the RC source.
	wdt_follow_a: assert property ($rose(lprc_osc_in) |-> ##[1:6] wdt_clk_tick)
		else $error("watchdog tick missing");
	sleep_quiet_a: assert property (
		sleep_active |-> !sys_clk_en && !periph_clk_en)
		else $error("clock runs in sleep");
	idle_quiet_a: assert property (idle_active |-> !sys_clk_en)
		else $error("core clock runs in idle");
	one_mode_a: assert property (!(sleep_active && idle_active))
		else $error("sleep and idle together");
	// Sleep ends only on a wake request.
	sleep_hold_a: assert property (
		sleep_active && !wake_req && !$past(wake_req) |=> sleep_active)
		else $error("sleep left without wake");

	cover property (sleep_active);
	cover property (idle_active && periph_clk_en);
	cover property ($fell(main_osc_enable));
endmodule : ccs_clock_switch_props

bind ccs_clock_switch ccs_clock_switch_props u_props (
	.core_clk(core_clk), .rst_n(rst_n), .avm_req(avm_req),
	.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
	.lprc_osc_in(lprc_osc_in), .wake_req(wake_req),
	.sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
	.main_osc_enable(main_osc_enable), .wdt_clk_tick(wdt_clk_tick),
	.sleep_active(sleep_active), .idle_active(idle_active));
`default_nettype wire

/* verif/system_clock_source_switch_tb.sv */
// Testbench: self-checking run of the clock source switch.
`default_nettype none
module system_clock_source_switch_tb
	import ccs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic         core_clk = 1'b0;   // 20 MHz core clock.
	logic         rst_n    = 1'b0;   // Asynchronous reset.
	ccs_avm_req_s avm_req  = '0;     // Bus request.
	logic [31:0]  avm_readdata;
	logic         avm_waitrequest;
	logic [3:0]   osc      = 4'h0;   // Primary, secondary, main, RC.
	logic         wake_req = 1'b0;
	logic         pri_done = 1'b1;   // Start-up timers expired.
	logic         int_ok   = 1'b1;   // Internal block stable.
	logic         sys_clk_en, periph_clk_en, main_osc_enable;
	logic         wdt_clk_tick, sleep_active, idle_active;
	logic [31:0]  rd;                // Last read data.
	int           failures  = 0;
	int           cmp_count = 0;
	int           pn        = 0;     // Peripheral enables counted.
	int           cyc       = 0;
	int           oc[4]     = '{0, 0, 0, 0};
	int           per[4]    = '{8, 10, 6, 14}; // Periods in core cycles.

	always #25 core_clk = ~core_clk;

	// Oscillators run free; each keeps half of its period high.
	always @(posedge core_clk) foreach (oc[i]) begin
		oc[i]  <= (oc[i] + 1) % per[i];
		osc[i] <= ((oc[i] + 1) % per[i]) < per[i] / 2;
	end

	// A hang ends the run as a failure.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			stop_test();
		end
	end

	ccs_clock_switch dut (
		.core_clk(core_clk), .rst_n(rst_n), .avm_req(avm_req),
		.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
		.pri_osc_in(osc[0]), .sec_osc_in(osc[1]), .main_osc_in(osc[2]),
		.lprc_osc_in(osc[3]), .pri_startup_done(pri_done),
		.int_osc_stable(int_ok), .wake_req(wake_req),
		.sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
		.main_osc_enable(main_osc_enable), .wdt_clk_tick(wdt_clk_tick),
		.sleep_active(sleep_active), .idle_active(idle_active));

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Rates may differ by one pulse because the window phase is free.
	task automatic chk_rate(string n, int e, int g);
		cmp_count++;
		if (g < e - 1 || g > e + 1) begin
			failures++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_rate

	// One bus access; the request is held until waitrequest is seen low.
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d,
			logic [3:0] be);
		@(posedge core_clk);
		avm_req <= '{read: !wr, write: wr, address: a, writedata: d,
			byteenable: be};
		do @(posedge core_clk); while (avm_waitrequest !== 1'b0);
		rd = avm_readdata;
		avm_req <= '0;
	endtask : bus

	// Lets a switch settle, then counts enables over 1536 cycles.
	task automatic count(output int n);
		n = 0;
		pn = 0;
		repeat (200) @(posedge core_clk);
		repeat (1536) @(posedge core_clk) begin
			if (sys_clk_en === 1'b1) n++;
			if (periph_clk_en === 1'b1) pn++;
		end
	endtask : count

	// Reset values, and an unmapped address that reads zero.
	task automatic check_reset();
		logic [3:0]  a[4] = '{CCS_OFF_OSC_CTRL, CCS_OFF_OSC_TUNE,
			CCS_OFF_SEC_CTRL, 4'h2};
		logic [31:0] e[4] = '{32'h0000_0048, 32'h0, 32'h0, 32'h0};
		foreach (a[i]) begin
			bus(1'b0, a[i], 32'h0, 4'hf);
			chk("reset value", e[i], rd);
		end
	endtask : check_reset

	initial begin
		int          n;
		int          e;
		logic [2:0]  code;
		logic        lf;
		logic [31:0] t;
		logic [31:0] d;
		logic [3:0]  be;
		void'($urandom(32'hd801));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		check_reset();
		count(n);
		chk_rate("primary rate", 192, n);
		$display("test reset done");
		// Secondary select is refused while its oscillator is off.
		bus(1'b1, CCS_OFF_OSC_CTRL, 32'h0000_0041, 4'hf);
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("refused select", 32'h0000_0048, rd);
		bus(1'b1, CCS_OFF_SEC_CTRL, 32'h0000_0008, 4'hf);
		bus(1'b1, CCS_OFF_OSC_CTRL, 32'h0000_0041, 4'hf);
		count(n);
		chk_rate("secondary rate", 154, n);
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("secondary ctrl", 32'h0000_0041, rd);
		bus(1'b0, CCS_OFF_SEC_CTRL, 32'h0, 4'hf);
		chk("secondary flag", 32'h0000_0048, rd);
		$display("test secondary done");
		// Every internal code, then code zero from both sources.
		for (int i = 0; i < 9; i++) begin
			code = (i < 7) ? 3'(7 - i) : 3'h0;
			lf = (i == 7);
			bus(1'b1, CCS_OFF_OSC_TUNE, {24'h0, lf, 7'h0}, 4'hf);
			// Odd passes use select code 11, which also means internal.
			bus(1'b1, CCS_OFF_OSC_CTRL, {25'h0, code, 3'h1, i[0]}, 4'hf);
			count(n);
			e = (code != 0) ? (256 >> (7 - code)) : (lf ? 1 : 109);
			chk_rate("internal rate", e, n);
			bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
			t = {25'h0, code, 1'b0, (code != 0 || lf), 1'b1, i[0]};
			chk("internal ctrl", t, rd);
			t = {31'h0, (code != 0 || lf)};
			chk("main enable", t, {31'h0, main_osc_enable});
		end
		$display("test internal done");
		// Power-down into sleep, then into idle, each left by a wake.
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, CCS_OFF_OSC_CTRL, {24'h0, i[0], 7'h72}, 4'hf);
			bus(1'b1, CCS_OFF_HALT, 32'h0000_0001, 4'hf);
			bus(1'b0, CCS_OFF_HALT, 32'h0, 4'hf);
			chk("halt mode", i ? 32'h2 : 32'h1, rd);
			count(n);
			chk_rate("halted rate", 0, n);
			chk_rate("peripheral rate", i ? 256 : 0, pn);
			@(posedge core_clk) wake_req <= 1'b1;
			@(posedge core_clk) wake_req <= 1'b0;
			repeat (4) @(posedge core_clk);
			chk("woken", 32'h0, {30'h0, sleep_active, idle_active});
		end
		$display("test power-down done");
		// Random tuning writes; a clear byte enable leaves it unchanged.
		t = 32'h0;
		repeat (6) begin
			d = $urandom;
			be = 4'($urandom);
			bus(1'b1, CCS_OFF_OSC_TUNE, d, be);
			if (be[0])
				t = {24'h0, d[7], 7'h0};
			bus(1'b0, CCS_OFF_OSC_TUNE, 32'h0, 4'hf);
			chk("tuning", t, rd);
		end
		$display("test random done");
		// The stable flag follows its input while internal drives.
		@(posedge core_clk) int_ok <= 1'b0;
		repeat (3) @(posedge core_clk);
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("unstable ctrl", 32'h0000_00F2, rd);
		int_ok <= 1'b1;
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("stable ctrl", 32'h0000_00F6, rd);
		$display("test status done");
		// A reset in mid-run restores every field.
		@(posedge core_clk) rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		check_reset();
		$display("test second reset done");
		// The primary flag waits for the start-up timers.
		pri_done <= 1'b0;
		repeat (3) @(posedge core_clk);
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("primary pending", 32'h0000_0040, rd);
		pri_done <= 1'b1;
		bus(1'b0, CCS_OFF_OSC_CTRL, 32'h0, 4'hf);
		chk("primary ready", 32'h0000_0048, rd);
		$display("test start-up done");
		stop_test();
	end
endmodule : system_clock_source_switch_tb
`default_nettype wire
